// [bench/fcs3_config_reg_sva.sv]
// assertions on the config register ports
`timescale 1ns/100ps
`default_nettype none
module fcs3_config_reg_sva
    import fcs3_pkg::*;
(
    input wire logic                     clk_sys,
    input wire logic                     rst_b,
    input wire logic                     device_reset,
    input wire fcs3_pkg::fcs3_wr_type    wr_req,
    input wire logic                     write_enable_latch,
    input wire logic                     wr_permit,
    input wire logic                     quad_io_enable,
    input wire fcs3_pkg::fcs3_check_type check_req,
    input wire logic [7:0]               reg_rd_data_ff,
    input wire logic                     hold_active_ff,
    input wire logic                     hw_reset_req_ff,
    input wire logic                     pins_are_data_ff,
    input wire logic                     wp_active_ff,
    input wire logic [1:0]               drive_strength_field_ff,
    input wire logic                     protect_scheme_select_ff,
    input wire logic                     check_done_ff,
    input wire logic                     pe_allowed_ff
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    wire logic quiet = !device_reset && !hw_reset_req_ff;
    a_rsvd_zero:
        assert property ((reg_rd_data_ff & 8'h1B) == 8'h00) else $error("reserved bits set");
    a_write_taken:
        assert property (wr_req.strobe && write_enable_latch && wr_permit && quiet
            |=> reg_rd_data_ff[7] == $past(wr_req.data[7])) else $error("write lost");
    a_write_refused:
        assert property (wr_req.strobe && !(write_enable_latch && wr_permit) && quiet
            |=> $stable(reg_rd_data_ff)) else $error("refused write landed");
    a_drv_code_keep:
        assert property (wr_req.strobe && wr_req.data[6:5] == 2'h0 && quiet
            |=> $stable(drive_strength_field_ff)) else $error("drive code 00 taken");
    a_qe_data_pins:
        assert property (quad_io_enable |=> pins_are_data_ff && !wp_active_ff)
            else $error("pins not data under quad");
    a_qe_no_ctrl:
        assert property (quad_io_enable && $past(quad_io_enable)
            |=> !hold_active_ff && !hw_reset_req_ff) else $error("pin control under quad");
    a_check_range:
        assert property (check_req.strobe && !protect_scheme_select_ff && check_req.range_hit
            |-> ##2 check_done_ff && !pe_allowed_ff) else $error("range hit allowed");
    a_check_done:
        assert property (check_req.strobe |-> ##2 check_done_ff)
            else $error("check result missing");
    a_dev_reset:
        assert property (device_reset |-> ##[1:2] reg_rd_data_ff == REG_RESET)
            else $error("device reset missed");
endmodule
`default_nettype wire

// [bench/fcs3_host_model.sv]
// host controller model: status write, lock and check requests
`timescale 1ns/100ps
`default_nettype none
module fcs3_host_model
    import fcs3_pkg::*;
(
    input  wire logic                     clk_sys,
    output var fcs3_pkg::fcs3_wr_type     wr_req,
    output var fcs3_pkg::fcs3_lock_type   lock_req,
    output var fcs3_pkg::fcs3_check_type  check_req
);
    initial
    begin
        wr_req = '0;
        lock_req = '0;
        check_req = '0;
    end
    task automatic step;
        @(posedge clk_sys);
        #2;
    endtask
    // one strobe cycle, level qualifiers come from the bench
    task automatic wr(input logic [7:0] d);
        step();
        wr_req = '{1'b1, d};
        step();
        wr_req = '0;
    endtask
    task automatic lk(input logic [7:0] op, input logic [6:0] b);
        step();
        lock_req = '{1'b1, op, b};
        step();
        lock_req = '0;
    endtask
    task automatic ck(input logic [6:0] b, input logic hit);
        step();
        check_req = '{1'b1, b, hit};
        step();
        check_req = '0;
    endtask
endmodule
`default_nettype wire

// [bench/tb_fcs3_config_reg.sv]
// self-checking bench for the config register
`timescale 1ns/100ps
`default_nettype none
module tb_fcs3_config_reg;
    import fcs3_pkg::*;
    logic           clk_sys;
    logic           rst_b;
    logic           device_reset;
    logic           write_enable_latch;
    logic           wr_permit;
    logic           quad_io_enable;
    logic           hold_reset_pin_b;
    logic           low_vcc;
    logic           wp_pin_b;
    fcs3_wr_type    wr_req;
    fcs3_lock_type  lock_req;
    fcs3_check_type check_req;
    logic [7:0]     reg_rd_data_ff, drive_pct_ff;
    logic [1:0]     drive_strength_field_ff;
    logic           hold_active_ff, hw_reset_req_ff, pins_are_data_ff, wp_active_ff;
    logic           protect_scheme_select_ff, check_done_ff, pe_allowed_ff;
    int             n_errors = 0;
    int             comparisons = 0;
    int             cycles = 0;
    fcs3_config_reg #(.BLOCKS(128)) dut (
        .clk_sys                  (clk_sys),
        .rst_b                    (rst_b),
        .device_reset             (device_reset),
        .wr_req                   (wr_req),
        .write_enable_latch       (write_enable_latch),
        .wr_permit                (wr_permit),
        .quad_io_enable           (quad_io_enable),
        .lock_req                 (lock_req),
        .check_req                (check_req),
        .hold_reset_pin_b         (hold_reset_pin_b),
        .low_vcc                  (low_vcc),
        .wp_pin_b                 (wp_pin_b),
        .reg_rd_data_ff           (reg_rd_data_ff),
        .hold_active_ff           (hold_active_ff),
        .hw_reset_req_ff          (hw_reset_req_ff),
        .pins_are_data_ff         (pins_are_data_ff),
        .wp_active_ff             (wp_active_ff),
        .drive_strength_field_ff  (drive_strength_field_ff),
        .drive_pct_ff             (drive_pct_ff),
        .protect_scheme_select_ff (protect_scheme_select_ff),
        .check_done_ff            (check_done_ff),
        .pe_allowed_ff            (pe_allowed_ff)
    );
    fcs3_host_model host (
        .clk_sys   (clk_sys),
        .wr_req    (wr_req),
        .lock_req  (lock_req),
        .check_req (check_req)
    );
    always #10 clk_sys = ~clk_sys;
    task automatic wrap_up;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            n_errors++;
            wrap_up();
        end
    end
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    task automatic ask(input logic [6:0] b, input logic hit, input logic exp);
        host.ck(b, hit);
        tick(1);
        chk("done", 8'h01, 8'(check_done_ff));
        chk("allowed", 8'(exp), 8'(pe_allowed_ff));
    endtask
    task automatic t_write;
        chk("reset", 8'h20, reg_rd_data_ff);
        chk("pct", 8'h64, drive_pct_ff);
        host.wr(8'hFF);
        tick(1);
        chk("all_ones", 8'hE4, reg_rd_data_ff);
        chk("scheme_1", 8'h01, 8'(protect_scheme_select_ff));
        host.wr(8'h00);
        tick(1);
        chk("code_00", 8'h60, reg_rd_data_ff);
        chk("scheme_0", 8'h00, 8'(protect_scheme_select_ff));
        write_enable_latch = 1'b0;
        host.wr(8'h24);
        tick(1);
        chk("no_wel", 8'h60, reg_rd_data_ff);
        write_enable_latch = 1'b1;
        wr_permit = 1'b0;
        host.wr(8'h24);
        tick(1);
        chk("no_permit", 8'h60, reg_rd_data_ff);
        wr_permit = 1'b1;
    endtask
    task automatic t_drive;
        logic [7:0] pct [6] = '{8'h64, 8'h42, 8'h21, 8'hA6, 8'h84, 8'h63};
        for (int v = 0; v < 2; v++)
        begin
            low_vcc = 1'(v);
            for (int c = 1; c < 4; c++)
            begin
                host.wr({1'b0, c[1:0], 5'h00});
                tick(5);
                chk("drive", 8'(c), 8'(drive_strength_field_ff));
                chk("pct", pct[v*3+c-1], drive_pct_ff);
            end
        end
        low_vcc = 1'b0;
    endtask
    task automatic t_pins;
        host.wr(8'h80);
        hold_reset_pin_b = 1'b0;
        tick(3);
        chk("hw_reset_pulse", 8'h01, 8'(hw_reset_req_ff));
        tick(9);
        chk("hw_reset", 8'h20, reg_rd_data_ff);
        chk("hold", 8'h01, 8'(hold_active_ff));
        quad_io_enable = 1'b1;
        wp_pin_b = 1'b0;
        host.wr(8'hA0);
        tick(8);
        chk("qe_no_reset", 8'hA0, reg_rd_data_ff);
        chk("qe_hold", 8'h00, 8'(hold_active_ff));
        chk("qe_data", 8'h01, 8'(pins_are_data_ff));
        hold_reset_pin_b = 1'b1;
        quad_io_enable = 1'b0;
        tick(5);
        chk("wp", 8'h01, 8'(wp_active_ff));
        wp_pin_b = 1'b1;
    endtask
    task automatic t_lock;
        host.wr(8'h24);
        tick(1);
        ask(7'h05, 1'b0, 1'b0);
        host.lk(8'h39, 7'h05);
        ask(7'h05, 1'b1, 1'b1);
        ask(7'h7F, 1'b0, 1'b0);
        host.lk(8'h3A, 7'h7F);
        ask(7'h7F, 1'b0, 1'b0);
        host.lk(8'h36, 7'h05);
        ask(7'h05, 1'b0, 1'b0);
        host.lk(8'h39, 7'h05);
        device_reset = 1'b1;
        tick(1);
        device_reset = 1'b0;
        tick(2);
        chk("dev_reset", 8'h20, reg_rd_data_ff);
        ask(7'h05, 1'b1, 1'b0);
        ask(7'h05, 1'b0, 1'b1);
        host.wr(8'h24);
        tick(1);
        ask(7'h05, 1'b0, 1'b0);
    endtask
    initial
    begin
        clk_sys = 1'b0;
        rst_b = 1'b0;
        device_reset = 1'b0;
        write_enable_latch = 1'b1;
        wr_permit = 1'b1;
        quad_io_enable = 1'b0;
        hold_reset_pin_b = 1'b1;
        low_vcc = 1'b0;
        wp_pin_b = 1'b1;
        repeat (20) @(posedge clk_sys);
        #2;
        rst_b = 1'b1;
        tick(2);
        t_write();
        t_drive();
        t_pins();
        t_lock();
        wrap_up();
    end
endmodule
bind fcs3_config_reg fcs3_config_reg_sva u_sva (
    .clk_sys                  (clk_sys),
    .rst_b                    (rst_b),
    .device_reset             (device_reset),
    .wr_req                   (wr_req),
    .write_enable_latch       (write_enable_latch),
    .wr_permit                (wr_permit),
    .quad_io_enable           (quad_io_enable),
    .check_req                (check_req),
    .reg_rd_data_ff           (reg_rd_data_ff),
    .hold_active_ff           (hold_active_ff),
    .hw_reset_req_ff          (hw_reset_req_ff),
    .pins_are_data_ff         (pins_are_data_ff),
    .wp_active_ff             (wp_active_ff),
    .drive_strength_field_ff  (drive_strength_field_ff),
    .protect_scheme_select_ff (protect_scheme_select_ff),
    .check_done_ff            (check_done_ff),
    .pe_allowed_ff            (pe_allowed_ff)
);
`default_nettype wire

// [src/fcs3_config_reg.sv]
// pin function, drive strength and write protect scheme register bank
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// RULE1 - bit 7 picks hold (0) or hardware reset (1) for the shared pin, read/write, default 0.
// RULE2 - the hold/reset choice only acts while quad enable is clear.
// RULE3 - with quad enable set the shared pin is only data and both control uses are ignored.
// RULE4 - bits 6:5 are a read/write drive field, default 01, used when driving read data.
// RULE5 - drive 01 is full, 10 two thirds, 11 one third, 00 reserved and not to be written.
// RULE6 - at low supply the strength is boosted 1.66x, 2x or 3x for full, two thirds, one third.
// RULE7 - bit 2 at 0 uses the range protection bits of the first status register.
// RULE8 - bit 2 at 1 ignores range bits and uses a lock bit per block for program and erase.
// RULE9 - every block lock bit is 1 after power-on and after any device reset.
// RULE10 - in per-block mode opcode 36h locks and 39h unlocks the addressed block.
// RULE11 - the host should tune the drive setting to its board instead of keeping the default.
// RULE12 - bits 4:3 and 1:0 read as 0 and writes to them are ignored.
// RULE13 - with quad enable set the write protect and hold/reset pins become data lines 3 and 4.
// RULE14 - the register changes only on a write status command with write enable latch set and writes permitted; code also loads REG_RESET on device reset.
module fcs3_config_reg
    import fcs3_pkg::*;
#(
    parameter int BLOCKS = fcs3_pkg::BLOCKS_DEF
) (
    input  wire logic                     clk_sys,
    input  wire logic                     rst_b,
    input  wire logic                     device_reset,
    input  wire fcs3_pkg::fcs3_wr_type    wr_req,
    input  wire logic                     write_enable_latch,
    input  wire logic                     wr_permit,
    input  wire logic                     quad_io_enable,
    input  wire fcs3_pkg::fcs3_lock_type  lock_req,
    input  wire fcs3_pkg::fcs3_check_type check_req,
    input  wire logic                     hold_reset_pin_b,
    input  wire logic                     low_vcc,
    input  wire logic                     wp_pin_b,
    output logic [7:0]                    reg_rd_data_ff,
    output logic                          hold_active_ff,
    output logic                          hw_reset_req_ff,
    output logic                          pins_are_data_ff,
    output logic                          wp_active_ff,
    output logic [1:0]                    drive_strength_field_ff,
    output logic [7:0]                    drive_pct_ff,
    output logic                          protect_scheme_select_ff,
    output logic                          check_done_ff,
    output logic                          pe_allowed_ff
);

    import fcs3_pkg::*;

    typedef struct packed {
        logic [7:0]        cfg;
        logic [1:0]        pin_sync;
        logic [1:0]        vcc_sync;
        logic [1:0]        wp_sync;
        fcs3_pin_mode_type mode;
        logic              data;
        logic [1:0]        qe_hist;
        logic              hold;
        logic              hwrst;
        logic              wp;
        logic [7:0]        pct;
        logic              chk_p1;
        logic              chk_scheme;
        logic              chk_hit;
        logic              done;
        logic              allowed;
    } fcs3_state_type;

    fcs3_state_type st_ff;
    fcs3_state_type nxt_st;
    logic           lock_rd;
    logic           any_reset;
    logic           lock_wr;

    function automatic logic [7:0] drive_pct(input logic [1:0] code, input logic lv);
        logic [7:0] p;
        p = PCT_FULL;
        case (code)
            DRV_TWO_THIRD: p = lv ? PCT_TWO_LV : PCT_TWO_THIRD; // RULE5 RULE6
            DRV_ONE_THIRD: p = lv ? PCT_ONE_LV : PCT_ONE_THIRD; // RULE5 RULE6
            default:       p = lv ? PCT_FULL_LV : PCT_FULL;     // RULE5 RULE6
        endcase
        return p;
    endfunction

    // opcode decode for the block lock and unlock commands
    function automatic logic is_lock_op(input logic [7:0] op);
        return (op == CMD_BLOCK_LOCK);
    endfunction

    function automatic logic is_unlock_op(input logic [7:0] op);
        return (op == CMD_BLOCK_UNLOCK);
    endfunction

    // device resets include the one raised by our own pin
    assign any_reset = device_reset | st_ff.hwrst;

    assign lock_wr = lock_req.strobe & st_ff.cfg[POS_SCHEME] &
                     (is_lock_op(lock_req.opcode) | is_unlock_op(lock_req.opcode)); // RULE10

    fcs3_lock_mem #(
        .BLOCKS     (BLOCKS),
        .AW         (BLK_AW)
    ) u_lock_mem (
        .clk_sys    (clk_sys),
        .rst_b      (rst_b),
        .lock_all   (any_reset),
        .wr_en      (lock_wr),
        .wr_val     (is_lock_op(lock_req.opcode)),
        .wr_addr    (lock_req.block),
        .rd_addr    (check_req.block),
        .rd_data_ff (lock_rd)
    );

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.pin_sync = {st_ff.pin_sync[0], hold_reset_pin_b};
        nxt_st.vcc_sync = {st_ff.vcc_sync[0], low_vcc};
        nxt_st.wp_sync  = {st_ff.wp_sync[0], wp_pin_b};

        if (any_reset)
        begin
            nxt_st.cfg = REG_RESET;
        end
        else if (wr_req.strobe && write_enable_latch && wr_permit) // RULE14
        begin
            nxt_st.cfg = wr_req.data & REG_RW_MASK; // RULE1 RULE4 RULE12
            if (wr_req.data[POS_DRV_HI:POS_DRV_LO] == DRV_RSVD)
            begin
                // reserved drive code keeps the old setting
                nxt_st.cfg[POS_DRV_HI:POS_DRV_LO] = st_ff.cfg[POS_DRV_HI:POS_DRV_LO]; // RULE5
            end
        end

        if (quad_io_enable)
        begin
            nxt_st.mode = PIN_DATA; // RULE3 RULE13
        end
        else if (st_ff.cfg[POS_PIN_SEL])
        begin
            nxt_st.mode = PIN_RESET; // RULE1 RULE2
        end
        else
        begin
            nxt_st.mode = PIN_HOLD; // RULE1 RULE2
        end

        nxt_st.data    = quad_io_enable; // RULE13
        nxt_st.qe_hist = {st_ff.qe_hist[0], quad_io_enable};

        nxt_st.hold  = 1'b0;
        nxt_st.hwrst = 1'b0;
        // pin samples taken while the pin carried data must not act
        if (st_ff.qe_hist == 2'h0) // RULE3
        begin
            case (st_ff.mode)
                PIN_HOLD:  nxt_st.hold  = ~st_ff.pin_sync[1]; // RULE2
                PIN_RESET: nxt_st.hwrst = ~st_ff.pin_sync[1] & ~st_ff.hwrst; // RULE2
                PIN_DATA:  nxt_st.hold  = 1'b0; // RULE3
                default:   nxt_st.hold  = 1'b0;
            endcase
        end
        nxt_st.wp = ~quad_io_enable & ~st_ff.wp_sync[1]; // RULE13

        nxt_st.pct = drive_pct(st_ff.cfg[POS_DRV_HI:POS_DRV_LO], st_ff.vcc_sync[1]); // RULE6

        nxt_st.chk_p1     = check_req.strobe;
        nxt_st.chk_scheme = st_ff.cfg[POS_SCHEME];
        nxt_st.chk_hit    = check_req.range_hit;
        nxt_st.done       = st_ff.chk_p1;
        if (st_ff.chk_p1)
        begin
            if (st_ff.chk_scheme)
            begin
                nxt_st.allowed = ~lock_rd; // RULE8
            end
            else
            begin
                nxt_st.allowed = ~st_ff.chk_hit; // RULE7
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_ff <= '{cfg: REG_RESET, pin_sync: 2'h3, vcc_sync: 2'h0, wp_sync: 2'h3,
                       mode: PIN_HOLD, data: 1'b0, qe_hist: 2'h0,
                       hold: 1'b0, hwrst: 1'b0, wp: 1'b0, pct: PCT_FULL,
                       chk_p1: 1'b0, chk_scheme: 1'b0, chk_hit: 1'b0, done: 1'b0,
                       allowed: 1'b0};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rd_data_ff           = st_ff.cfg; // RULE12
    assign hold_active_ff           = st_ff.hold;
    assign hw_reset_req_ff          = st_ff.hwrst;
    assign pins_are_data_ff         = st_ff.data; // RULE13
    assign wp_active_ff             = st_ff.wp;
    assign drive_strength_field_ff  = st_ff.cfg[POS_DRV_HI:POS_DRV_LO]; // RULE4
    assign drive_pct_ff             = st_ff.pct;
    assign protect_scheme_select_ff = st_ff.cfg[POS_SCHEME];
    assign check_done_ff            = st_ff.done;
    assign pe_allowed_ff            = st_ff.allowed;

endmodule

`default_nettype wire

// [src/fcs3_lock_mem.sv]
// per-block lock bit store with registered lookup
`timescale 1ns/100ps
`default_nettype none

module fcs3_lock_mem #(
    parameter int BLOCKS = 128,
    parameter int AW     = 7
) (
    input  wire logic          clk_sys,
    input  wire logic          rst_b,
    input  wire logic          lock_all,
    input  wire logic          wr_en,
    input  wire logic          wr_val,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [AW-1:0] rd_addr,
    output var  logic          rd_data_ff
);

    typedef struct packed {
        logic [BLOCKS-1:0] bits;
        logic              rd;
    } fcs3_mem_type;

    fcs3_mem_type st_ff;
    fcs3_mem_type nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        if (lock_all)
        begin
            nxt_st.bits = '1; // RULE9
        end
        else if (wr_en)
        begin
            nxt_st.bits[wr_addr] = wr_val; // RULE10
        end
        nxt_st.rd = st_ff.bits[rd_addr];
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_ff <= '1; // RULE9
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign rd_data_ff = st_ff.rd;

endmodule

`default_nettype wire

// [src/fcs3_pkg.sv]
// package of constants and carrier types for the pin, drive and protect config register
package fcs3_pkg;

    localparam int          REG_W          = 8;
    localparam int          POS_PIN_SEL    = 7;
    localparam int          POS_DRV_LO     = 5;
    localparam int          POS_DRV_HI     = 6;
    localparam int          POS_SCHEME     = 2;
    localparam logic [7:0]  REG_RESET      = 8'h20;
    localparam logic [7:0]  REG_RW_MASK    = 8'hE4;

    localparam logic [1:0]  DRV_RSVD       = 2'h0;
    localparam logic [1:0]  DRV_FULL       = 2'h1;
    localparam logic [1:0]  DRV_TWO_THIRD  = 2'h2;
    localparam logic [1:0]  DRV_ONE_THIRD  = 2'h3;

    // strength in percent of full, nominal and boosted at low supply
    localparam logic [7:0]  PCT_FULL       = 8'h64;
    localparam logic [7:0]  PCT_TWO_THIRD  = 8'h42;
    localparam logic [7:0]  PCT_ONE_THIRD  = 8'h21;
    localparam logic [7:0]  PCT_FULL_LV    = 8'hA6;
    localparam logic [7:0]  PCT_TWO_LV     = 8'h84;
    localparam logic [7:0]  PCT_ONE_LV     = 8'h63;

    localparam logic [7:0]  CMD_BLOCK_LOCK   = 8'h36;
    localparam logic [7:0]  CMD_BLOCK_UNLOCK = 8'h39;

    localparam int          BLOCKS_DEF     = 128;
    localparam int          BLK_AW         = 7;

    typedef struct packed {
        logic             strobe;
        logic [REG_W-1:0] data;
    } fcs3_wr_type;

    typedef struct packed {
        logic             strobe;
        logic [7:0]       opcode;
        logic [BLK_AW-1:0] block;
    } fcs3_lock_type;

    typedef struct packed {
        logic             strobe;
        logic [BLK_AW-1:0] block;
        logic             range_hit;
    } fcs3_check_type;

    typedef enum logic [1:0] {
        PIN_HOLD  = 2'b00,
        PIN_RESET = 2'b01,
        PIN_DATA  = 2'b10
    } fcs3_pin_mode_type;

endpackage
